// ---- testbench/srs_step_rate_selector_bench.sv ----
// bench for the step rate selector: loads, rate decode and step timing
// assumes the step sink model and a 50 MHz clock
`timescale 1ns/10ps
// ***********************
// bench
// ***********************
module srs_step_rate_selector_bench;
   logic sys_clk = 1'b0, rst = 1'b1, param_load = 1'b0, motion_run = 1'b0;
   logic [1:0] step_mode = 2'h0, group_ff;
   logic [3:0] vmax_idx = 4'h0;
   logic [9:0] full_rate_ff;
   logic [13:0] micro_rate_ff;
   logic group_err_ff, step_pulse_ff;
   int n_steps, last_gap, n_mismatch = 0, checked = 0;
   int rate [16] = '{99, 136, 167, 197, 213, 228, 243, 273, 303, 334, 364, 395, 456, 546, 729,
      973};
   always #10 sys_clk = ~sys_clk;
   srs_step_rate_selector srs_step_rate_selector_inst (.sys_clk(sys_clk), .rst(rst),
      .param_load(param_load), .step_mode(step_mode), .vmax_idx(vmax_idx),
      .motion_run(motion_run), .full_rate_ff(full_rate_ff), .micro_rate_ff(micro_rate_ff),
      .group_ff(group_ff), .group_err_ff(group_err_ff), .step_pulse_ff(step_pulse_ff));
   srs_step_sink srs_step_sink_inst (.sys_clk(sys_clk), .rst(rst), .step_pulse(step_pulse_ff),
      .n_steps(n_steps), .last_gap(last_gap));
   task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH %s expected %0d seen %0d", nm, exp, got);
      end
   endtask : chk
   task end_sim;
      if (n_mismatch == 0 && checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : end_sim
   task load(input logic [1:0] m, input logic [3:0] i);
      @(negedge sys_clk);
      param_load = 1'b1;
      step_mode = m;
      vmax_idx = i;
      @(negedge sys_clk);
      param_load = 1'b0;
      repeat (2) @(negedge sys_clk);
   endtask : load
   task gap(output int g);
      int n0;
      n0 = n_steps;
      for (int i = 0; i < 40000 && n_steps == n0; i++) @(negedge sys_clk);
      // a missing pulse must not reuse the previous gap
      g = (n_steps == n0) ? 0 : last_gap;
   endtask : gap
   task t_reset;
      @(negedge sys_clk);
      chk("rst_full", full_rate_ff, 0);
      repeat (3) @(negedge sys_clk);
      rst = 1'b0;
      repeat (2) @(negedge sys_clk);
      chk("full0", full_rate_ff, 99);
      chk("micro0", micro_rate_ff, 198);
      chk("grp0", group_ff, 0);
   endtask : t_reset
   task t_table;
      for (int m = 0; m < 4; m++) begin
         for (int i = 0; i < 16; i++) begin
            load(m[1:0], i[3:0]);
            chk("full", full_rate_ff, rate[i]);
            chk("micro", micro_rate_ff, rate[i] << (m + 1));
            chk("grp", group_ff, i < 3 ? 0 : i < 6 ? 1 : i < 13 ? 2 : 3);
         end
      end
   endtask : t_table
   task t_steps;
      int g, n0;
      load(2'h3, 4'hf);
      motion_run = 1'b1;
      @(negedge sys_clk);
      chk("first", step_pulse_ff, 1);
      gap(g);
      chk("width", step_pulse_ff, 0);
      gap(g);
      chk("per_f", g, (srs_pkg::CLK_HZ / 973) >> 4);
      gap(g);
      chk("per_f2", g, 3211);
      load(2'h3, 4'hd);
      gap(g);
      gap(g);
      chk("per_d", g, (srs_pkg::CLK_HZ / 546) >> 4);
      chk("err_in", group_err_ff, 0);
      load(2'h3, 4'h0);
      chk("err_x", group_err_ff, 1);
      chk("full_x", full_rate_ff, 99);
      motion_run = 1'b0;
      n0 = n_steps;
      repeat (4000) @(negedge sys_clk);
      chk("idle", n_steps, n0);
      rst = 1'b1;
      @(negedge sys_clk);
      chk("err_rst", group_err_ff, 0);
      chk("full_rst", full_rate_ff, 0);
      rst = 1'b0;
      repeat (2) @(negedge sys_clk);
      chk("full_rel", full_rate_ff, 99);
      chk("micro_rel", micro_rate_ff, 198);
   endtask : t_steps
   initial begin
      repeat (60000) @(posedge sys_clk);
      n_mismatch++;
      end_sim;
   end
   initial begin
      t_reset;
      t_table;
      t_steps;
      end_sim;
   end
endmodule : srs_step_rate_selector_bench

// ---- testbench/srs_step_sink.sv ----
// step sink: stands in for the coil drivers and times the step pulses
// assumes step pulses are one cycle wide and synchronous to sys_clk
`timescale 1ns/10ps
// ***********************
// step sink
// ***********************
module srs_step_sink (
   input wire logic sys_clk, // clock
   input wire logic rst, // async reset
   input wire logic step_pulse, // step from the block
   output int n_steps, // pulses seen
   output int last_gap // cycles between the last two pulses
);
   int cnt;
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         cnt <= 0;
         n_steps <= 0;
         last_gap <= 0;
      end else if (step_pulse) begin
         last_gap <= cnt + 1;
         cnt <= 0;
         n_steps <= n_steps + 1;
      end else begin
         cnt <= cnt + 1;
      end
   end
endmodule : srs_step_sink

// ---- verilog/srs_rate_rom.sv ----
// step rate selector: shared constants and the velocity decode table
// assumes a 50 MHz sys_clk and purely combinational use by the main block
`timescale 1ns/10ps

// ************************************************
// constants
// ************************************************
package srs_pkg;
   localparam int unsigned CLK_HZ = 50_000_000;
   localparam int FULL_W = 10;
   localparam int MICRO_W = 14;
   localparam int PER_W = 19;
   localparam logic [3:0] IDX_RST = 4'h0;
   localparam logic [1:0] GRP_A = 2'h0;
   localparam logic [1:0] GRP_B = 2'h1;
   localparam logic [1:0] GRP_C = 2'h2;
   localparam logic [1:0] GRP_D = 2'h3;
   localparam logic [3:0] GRP_B_FIRST = 4'h3;
   localparam logic [3:0] GRP_C_FIRST = 4'h6;
   localparam logic [3:0] GRP_D_FIRST = 4'hd;
   localparam logic [PER_W-1:0] PER_RST = 19'h00001;

   typedef enum logic [1:0] {
      SRS_HALF = 2'b00,
      SRS_QUARTER = 2'b01,
      SRS_EIGHTH = 2'b10,
      SRS_SIXTEENTH = 2'b11
   } srs_mode_t;

   // full steps per second, ascending with the index
   function automatic logic [FULL_W-1:0] srs_full_rate(input logic [3:0] idx);
      logic [FULL_W-1:0] r;
      r = 10'h063;
      unique case (idx)
         4'h0: r = 10'h063;
         4'h1: r = 10'h088;
         4'h2: r = 10'h0a7;
         4'h3: r = 10'h0c5;
         4'h4: r = 10'h0d5;
         4'h5: r = 10'h0e4;
         4'h6: r = 10'h0f3;
         4'h7: r = 10'h111;
         4'h8: r = 10'h12f;
         4'h9: r = 10'h14e;
         4'ha: r = 10'h16c;
         4'hb: r = 10'h18b;
         4'hc: r = 10'h1c8;
         4'hd: r = 10'h222;
         4'he: r = 10'h2d9;
         4'hf: r = 10'h3cd;
      endcase
      return r;
   endfunction : srs_full_rate

   // micro steps per full step, as a shift
   function automatic logic [2:0] srs_shift(input srs_mode_t m);
      return {1'b0, m} + 3'h1;
   endfunction : srs_shift
endpackage : srs_pkg

// ************************************************
// decode of index and mode into rates and period
// ************************************************
module srs_rate_rom (
   input wire logic [3:0] vmax_idx, // velocity index
   input wire srs_pkg::srs_mode_t mode, // stepping resolution
   output logic [srs_pkg::FULL_W-1:0] full_rate, // full steps per second
   output logic [srs_pkg::MICRO_W-1:0] micro_rate, // micro steps per second
   output logic [srs_pkg::PER_W-1:0] period, // sys_clk cycles per micro step
   output logic [1:0] group // velocity group A..D
);
   wire [31:0] full_per;
   wire [2:0] sh;

   assign full_rate = srs_pkg::srs_full_rate(vmax_idx);
   assign sh = srs_pkg::srs_shift(mode);
   assign micro_rate = srs_pkg::MICRO_W'({4'h0, full_rate} << sh);
   // the oscillator divided by the rate; truncation is well under 0.1 %
   assign full_per = srs_pkg::CLK_HZ / {22'h0, full_rate};
   assign period = srs_pkg::PER_W'(full_per >> sh);
   assign group = (vmax_idx >= srs_pkg::GRP_D_FIRST) ? srs_pkg::GRP_D :
                  (vmax_idx >= srs_pkg::GRP_C_FIRST) ? srs_pkg::GRP_C :
                  (vmax_idx >= srs_pkg::GRP_B_FIRST) ? srs_pkg::GRP_B :
                  srs_pkg::GRP_A;
endmodule : srs_rate_rom

// ---- verilog/srs_step_rate_selector.sv ----
// step rate selector: latches stepping mode and velocity index, times steps
// assumes inputs synchronous to sys_clk; no register bus, plain ports only
//
// Overview of operation
// - four stepping resolutions: half, quarter, eighth, sixteenth.
// - sixteen velocity indexes 0 to f for every resolution.
// - index decodes to fixed full-step rates, 99 up to 973 per second.
// - micro-step rate is full rate times 2, 4, 8 or 16.
// - step timing derives from the on-chip clock.
// - a new velocity index is taken and applied during motion.
// - indexes fall into four groups A to D by rising speed.

`timescale 1ns/10ps

module srs_step_rate_selector (
   input wire logic sys_clk, // 50 MHz clock
   input wire logic rst, // async reset, active high
   input wire logic param_load, // one-cycle strobe: take mode and index
   input wire logic [1:0] step_mode, // resolution code
   input wire logic [3:0] vmax_idx, // velocity index
   input wire logic motion_run, // level: motion in progress
   output logic [srs_pkg::FULL_W-1:0] full_rate_ff, // full steps per second
   output logic [srs_pkg::MICRO_W-1:0] micro_rate_ff, // micro steps per second
   output logic [1:0] group_ff, // group of the active index
   output logic group_err_ff, // sticky: cross-group change during motion
   output logic step_pulse_ff // one-cycle step pulse
);
   // ************************************************
   // parameter latch
   // ************************************************
   srs_pkg::srs_mode_t mode_ff;
   logic [3:0] idx_ff;
   logic [srs_pkg::PER_W-1:0] period_ff;
   logic [srs_pkg::PER_W-1:0] cnt_ff;
   logic run_ff;

   srs_pkg::srs_mode_t nxt_mode;
   logic [3:0] nxt_idx;
   wire [srs_pkg::FULL_W-1:0] dec_full;
   wire [srs_pkg::MICRO_W-1:0] dec_micro;
   wire [srs_pkg::PER_W-1:0] dec_period;
   wire [1:0] dec_group;
   wire [1:0] new_group;
   wire cross_group;
   wire expire;
   logic [srs_pkg::PER_W-1:0] nxt_cnt;

   assign nxt_mode = param_load ? srs_pkg::srs_mode_t'(step_mode) : mode_ff;
   // loads are honoured whether or not a motion is running
   assign nxt_idx = param_load ? vmax_idx : idx_ff;

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         mode_ff <= srs_pkg::SRS_HALF;
         idx_ff <= srs_pkg::IDX_RST;
      end else begin
         mode_ff <= nxt_mode;
         idx_ff <= nxt_idx;
      end
   end

   srs_rate_rom u_rom (
      .vmax_idx(idx_ff),
      .mode(mode_ff),
      .full_rate(dec_full),
      .micro_rate(dec_micro),
      .period(dec_period),
      .group(dec_group)
   );

   // ************************************************
   // decoded outputs and group watch
   // ************************************************
   srs_rate_rom u_grp (
      .vmax_idx(vmax_idx),
      .mode(mode_ff),
      .full_rate(),
      .micro_rate(),
      .period(),
      .group(new_group)
   );

   // only flagged; the step timing still follows the new index
   assign cross_group = param_load && motion_run && (new_group != group_ff);

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         full_rate_ff <= '0;
         micro_rate_ff <= '0;
         group_ff <= srs_pkg::GRP_A;
         period_ff <= srs_pkg::PER_RST;
         group_err_ff <= 1'b0;
      end else begin
         full_rate_ff <= dec_full;
         micro_rate_ff <= dec_micro;
         group_ff <= dec_group;
         period_ff <= dec_period;
         group_err_ff <= group_err_ff | cross_group;
      end
   end

   // ************************************************
   // step period counter
   // ************************************************
   // new period takes effect at the next expiry, so no step is cut short
   assign expire = motion_run && (cnt_ff == '0);
   assign nxt_cnt = !motion_run ? '0 :
                    expire ? period_ff - srs_pkg::PER_RST : cnt_ff - srs_pkg::PER_RST;

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         cnt_ff <= '0;
         step_pulse_ff <= 1'b0;
         run_ff <= 1'b0;
      end else begin
         cnt_ff <= nxt_cnt;
         step_pulse_ff <= expire;
         run_ff <= motion_run;
      end
   end

   // ************************************************
   // check helper: spacing of the steps
   // ************************************************
   // feeds only the assertions and covers below; it drives no output
   logic [srs_pkg::PER_W-1:0] since_ff;
   logic [srs_pkg::PER_W-1:0] span_ff;
   wire [srs_pkg::PER_W-1:0] nxt_since;
   wire [srs_pkg::PER_W-1:0] nxt_span;

   assign nxt_since = !motion_run ? '0 : expire ? 19'h00001 : since_ff + 19'h00001;
   assign nxt_span = expire ? period_ff : span_ff;

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         since_ff <= '0;
         span_ff <= '0;
      end else begin
         since_ff <= nxt_since;
         span_ff <= nxt_span;
      end
   end

   // ************************************************
   // assertions
   // ************************************************
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   micro_mult_a: assert property (
      micro_rate_ff == srs_pkg::MICRO_W'({4'h0, full_rate_ff}
                       << srs_pkg::srs_shift(mode_ff)) || $changed(idx_ff) ||
      $changed(mode_ff))
      else $error("micro rate not full rate times resolution");
   full_table_a: assert property (
      param_load |=> ##1 full_rate_ff == srs_pkg::srs_full_rate($past(vmax_idx, 2)))
      else $error("full rate does not match index");
   idx_during_run_a: assert property (
      (param_load && motion_run) |=> idx_ff == $past(vmax_idx))
      else $error("index change ignored during motion");
   mode_taken_a: assert property (
      param_load |=> mode_ff == $past(step_mode))
      else $error("stepping mode not taken");
   pulse_run_a: assert property (
      step_pulse_ff |-> run_ff && $past(cnt_ff) == '0)
      else $error("step pulse without motion");
   pulse_reload_a: assert property (
      (step_pulse_ff && motion_run) |-> cnt_ff == $past(period_ff) - srs_pkg::PER_RST)
      else $error("counter not reloaded with period");
   period_value_a: assert property (
      $stable(idx_ff) && $stable(mode_ff) |=> period_ff == srs_pkg::PER_W'(
         (srs_pkg::CLK_HZ / {22'h0, srs_pkg::srs_full_rate($past(idx_ff))})
         >> srs_pkg::srs_shift($past(mode_ff))))
      else $error("period not derived from clock");
   group_order_a: assert property (
      param_load |=> ##1 (group_ff == srs_pkg::GRP_A) == ($past(vmax_idx, 2) < 4'h3))
      else $error("group A decode wrong");
   group_flag_a: assert property (
      cross_group |=> group_err_ff)
      else $error("cross-group change not flagged");
   pulse_width_a: assert property (
      step_pulse_ff |=> !step_pulse_ff)
      else $error("step pulse wider than one cycle");
   idle_quiet_a: assert property (
      !motion_run |=> !step_pulse_ff)
      else $error("step pulse while idle");
   idle_count_a: assert property (
      !motion_run |=> cnt_ff == '0)
      else $error("counter not cleared while idle");
   start_pulse_a: assert property (
      $rose(motion_run) |=> step_pulse_ff)
      else $error("no step at motion start");
   count_down_a: assert property (
      (motion_run && cnt_ff != '0) |=> $past(cnt_ff) - cnt_ff == 19'h00001)
      else $error("counter not counting down");
   step_spacing_a: assert property (
      (expire && since_ff != '0) |-> since_ff == span_ff)
      else $error("step spacing differs from period");
   err_sticky_a: assert property (
      group_err_ff |=> group_err_ff)
      else $error("group error flag dropped");
   err_cause_a: assert property (
      $rose(group_err_ff) |-> $past(cross_group))
      else $error("group error flag without cause");
   idx_hold_a: assert property (
      $changed(idx_ff) |-> $past(param_load))
      else $error("index changed without load");
   mode_hold_a: assert property (
      $changed(mode_ff) |-> $past(param_load))
      else $error("mode changed without load");
   group_top_a: assert property (
      group_ff == srs_pkg::GRP_D |-> full_rate_ff >= srs_pkg::srs_full_rate(srs_pkg::GRP_D_FIRST))
      else $error("group D below its first rate");
   group_low_a: assert property (
      group_ff == srs_pkg::GRP_A |-> full_rate_ff < srs_pkg::srs_full_rate(srs_pkg::GRP_B_FIRST))
      else $error("group A above group B rates");

   hi_speed_c: cover property (param_load && vmax_idx == 4'hf && step_mode == 2'b11);
   two_pulses_c: cover property (expire && since_ff != '0);
   run_change_c: cover property (param_load && motion_run && !cross_group);
   group_err_c: cover property ($rose(group_err_ff));
   new_period_c: cover property (expire && since_ff != '0 && span_ff != period_ff);
endmodule : srs_step_rate_selector
